/* File: hdl/hold_filter.sv */
`timescale 1ns/1ps
module hold_filter #(
  parameter int CW = 32,
  parameter logic [CW-1:0] LIMIT = '1
) (
  input  wire logic mclk,
  input  wire logic nrst,
  input  wire logic level,
  output logic      held
);
  logic [CW-1:0] cnt_ff;
  // Output only after level stays high LIMIT cycles
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt_ff <= '0;
      held   <= 1'b0;
    end else if (!level) begin
      cnt_ff <= '0;
      held   <= 1'b0;
    end else if (cnt_ff >= LIMIT - 1'b1) begin
      held   <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end
endmodule : hold_filter

/* File: hdl/reset_and_io_register_map.sv */
`timescale 1ns/1ps
module reset_and_io_register_map #(
  parameter int     PIN_CYCLES = rstio_pkg::PIN_CYC,
  parameter longint KEY_CYCLES = rstio_pkg::KEY_CYC
) (
  input  wire logic       mclk,
  input  wire logic       nrst,
  input  wire logic       osc_clk,
  input  wire logic       reset_pin,
  input  wire logic [3:0] key_in,
  input  wire logic [1:0] key_sel,
  input  wire logic       bit0_is_clock_out,
  input  wire logic       mem_rd,
  input  wire logic       mem_wr,
  input  wire logic [7:0] mem_addr,
  input  wire logic [3:0] mem_wdata,
  output logic      [3:0] mem_rdata,
  output logic            mem_hit,
  output logic            init_reset,
  output logic      [7:0] pc_step_init,
  output logic      [3:0] pc_page_init,
  output logic      [3:0] npp_init,
  output logic            flags_clear,
  output logic      [3:0] out_pins,
  output logic            clock_out_enable,
  output logic            tone_inv_enable,
  output logic            tone_enable,
  output logic            tick2_irq_enable,
  output logic            tick16_irq_enable,
  output logic            tick32_irq_enable,
  output logic            key_irq_flag,
  output logic            key_irq
);
  ////////////////////////////////////////////////////////////////////////////
  logic       osc_s;
  logic       pin_s;
  logic [3:0] key_s;
  logic       pin_held;
  logic       key_held;
  logic       combo_high;
  logic       osc_prev_ff;
  logic [7:0] osc_idle_ff;
  logic       osc_ok_ff;
  logic       osc_tick;
  logic       rst_any;

  sync2 u_sync_osc (.mclk(mclk), .nrst(nrst), .din(osc_clk), .dout(osc_s));
  sync2 u_sync_pin (.mclk(mclk), .nrst(nrst), .din(reset_pin), .dout(pin_s));
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_key
      sync2 u_sync_key (.mclk(mclk), .nrst(nrst), .din(key_in[gi]), .dout(key_s[gi]));
    end
  endgenerate

  // Oscillator alive watch: idle count of mclk between edges
  assign osc_tick = osc_s & ~osc_prev_ff;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      osc_prev_ff <= 1'b0;
      osc_idle_ff <= 8'h00;
      osc_ok_ff   <= 1'b0;
    end else begin
      osc_prev_ff <= osc_s;
      if (osc_tick) begin
        osc_idle_ff <= 8'h00;
        osc_ok_ff   <= 1'b1;
      end else if (osc_idle_ff == 8'(rstio_pkg::OSC_LOST)) begin
        osc_ok_ff   <= 1'b0;
      end else begin
        osc_idle_ff <= osc_idle_ff + 8'h01;
      end
    end
  end

  hold_filter #(.CW(32), .LIMIT(32'(PIN_CYCLES))) u_pin_filt (
    .mclk(mclk), .nrst(nrst), .level(pin_s), .held(pin_held)
  );

  always_comb begin
    case (rstio_pkg::keysel_type'(key_sel))
      rstio_pkg::KEYSEL_01:  combo_high = &key_s[1:0];
      rstio_pkg::KEYSEL_012: combo_high = &key_s[2:0];
      rstio_pkg::KEYSEL_ALL: combo_high = &key_s;
      default:               combo_high = 1'b0;
    endcase
  end

  hold_filter #(.CW(40), .LIMIT(40'(KEY_CYCLES))) u_key_filt (
    .mclk(mclk), .nrst(nrst), .level(combo_high), .held(key_held)
  );

  // Pin reset lasts while pin high after filter; release on low
  assign rst_any = ~osc_ok_ff | (pin_held & pin_s) | key_held;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      init_reset   <= 1'b1;
      pc_step_init <= rstio_pkg::PC_STEP_RST;
      pc_page_init <= rstio_pkg::PC_PAGE_RST;
      npp_init     <= rstio_pkg::NPP_RST;
      flags_clear  <= 1'b1;
    end else begin
      init_reset   <= rst_any;
      pc_step_init <= rstio_pkg::PC_STEP_RST;
      pc_page_init <= rstio_pkg::PC_PAGE_RST;
      npp_init     <= rstio_pkg::NPP_RST;
      flags_clear  <= rst_any;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock timer divider off the oscillator
  logic [rstio_pkg::DIV_BITS-1:0] div_ff;
  logic [3:0] outs_ff;
  logic [3:0] keyen_ff;
  logic [2:0] tken_ff;
  logic       kflag_ff;
  logic [3:0] key_prev_ff;
  logic       io_wr;
  logic       key_event;
  logic       flag_rd;
  logic [3:0] nxt_rdata;
  logic       nxt_hit;
  logic [7:0] addr_pg0;

  // Data page is always zero; only low byte decodes
  assign addr_pg0 = mem_addr;
  assign io_wr    = mem_wr & ~init_reset;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      div_ff <= '0;
    end else if (init_reset) begin
      div_ff <= '0;
    end else if (io_wr && addr_pg0 == rstio_pkg::ADDR_TMCTL &&
                 mem_wdata[rstio_pkg::BIT_TMCLR]) begin
      div_ff <= '0;
    end else if (osc_tick) begin
      div_ff <= div_ff + 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      outs_ff <= rstio_pkg::NIB_RESET;
    end else if (init_reset) begin
      outs_ff <= rstio_pkg::NIB_RESET;
    end else if (io_wr && addr_pg0 == rstio_pkg::ADDR_OUTS) begin
      outs_ff <= mem_wdata;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      keyen_ff <= rstio_pkg::NIB_RESET;
    end else if (init_reset) begin
      keyen_ff <= rstio_pkg::NIB_RESET;
    end else if (io_wr && addr_pg0 == rstio_pkg::ADDR_KEYEN) begin
      keyen_ff <= mem_wdata;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      tken_ff <= 3'h0;
    end else if (init_reset) begin
      tken_ff <= 3'h0;
    end else if (io_wr && addr_pg0 == rstio_pkg::ADDR_TMCTL) begin
      tken_ff <= mem_wdata[2:0];
    end
  end

  // Change on an enabled key sets the flag; set beats read clear
  assign key_event = |((key_s ^ key_prev_ff) & keyen_ff);
  assign flag_rd   = mem_rd & ~init_reset & (addr_pg0 == rstio_pkg::ADDR_KEYFLG);
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      key_prev_ff <= 4'h0;
      kflag_ff    <= 1'b0;
    end else begin
      key_prev_ff <= key_s;
      if (init_reset) begin
        kflag_ff <= 1'b0;
      end else if (key_event) begin
        kflag_ff <= 1'b1;
      end else if (flag_rd) begin
        kflag_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read decode, one nibble per access
  always_comb begin
    nxt_rdata = 4'h0;
    nxt_hit   = 1'b1;
    if (addr_pg0 == rstio_pkg::ADDR_KEYS) begin
      nxt_rdata = key_s;
    end else if (addr_pg0 == rstio_pkg::ADDR_OUTS) begin
      nxt_rdata = outs_ff;
    end else if (addr_pg0 == rstio_pkg::ADDR_TAPS) begin
      nxt_rdata = div_ff[rstio_pkg::TAP2_BIT:rstio_pkg::TAP16_BIT];
    end else if (addr_pg0 == rstio_pkg::ADDR_KEYEN) begin
      nxt_rdata = keyen_ff;
    end else if (addr_pg0 == rstio_pkg::ADDR_TMCTL) begin
      nxt_rdata = {1'b0, tken_ff};
    end else if (addr_pg0 == rstio_pkg::ADDR_KEYFLG) begin
      nxt_rdata = {3'b000, kflag_ff};
    end else begin
      nxt_hit   = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      mem_rdata <= 4'h0;
      mem_hit   <= 1'b0;
    end else if (mem_rd && !init_reset) begin
      mem_rdata <= nxt_rdata;
      mem_hit   <= nxt_hit;
    end else begin
      mem_rdata <= 4'h0;
      mem_hit   <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      out_pins          <= 4'h0;
      clock_out_enable  <= 1'b0;
      tone_inv_enable   <= 1'b0;
      tone_enable       <= 1'b0;
      tick2_irq_enable  <= 1'b0;
      tick16_irq_enable <= 1'b0;
      tick32_irq_enable <= 1'b0;
      key_irq_flag      <= 1'b0;
      key_irq           <= 1'b0;
    end else begin
      out_pins          <= outs_ff;
      clock_out_enable  <= outs_ff[0] & bit0_is_clock_out;
      tone_inv_enable   <= outs_ff[0] & ~bit0_is_clock_out;
      tone_enable       <= outs_ff[1];
      tick2_irq_enable  <= tken_ff[rstio_pkg::BIT_T2EN];
      tick16_irq_enable <= tken_ff[rstio_pkg::BIT_T16EN];
      tick32_irq_enable <= tken_ff[rstio_pkg::BIT_T32EN];
      key_irq_flag      <= kflag_ff;
      key_irq           <= kflag_ff;
    end
  end
endmodule : reset_and_io_register_map

/* File: hdl/rstio_pkg.sv */
// What this block does
// - Three reset sources: oscillator, pin, keys
// - Oscillator stopped holds reset asserted
// - Reset pin filtered, five milliseconds minimum
// - Pin low releases reset, CPU runs
// - Key combination filtered, four seconds minimum
// - Key option: off, 0-1, 0-2, 0-3
// - CPU reset values: step 00H, page 1H
// - Program memory three pages, vectors page one
// - Sleep instruction unsupported
// - Data page fixed zero, index pages ignored
// - Calls and interrupts push three words
// - Addresses 000H-00FH form register window
// - RAM, write-only display, I/O; rest empty
// - Peripherals reached only through I/O memory
// - 0F1H output latches and tone enables
// - 0F2H reads timer taps 16 to 2 Hz
// - 0F3H key interrupt enables, reset zero
// - 0F4H timer clear and tick enables
// - 0F5H bit 0 key flag, rest zero
// - Interrupt flag clears when read
// - Constant-zero and write-only bits read zero
// - Enabled key change sets key flag
package rstio_pkg;
  localparam logic [7:0] ADDR_KEYS   = 8'hF0;
  localparam logic [7:0] ADDR_OUTS   = 8'hF1;
  localparam logic [7:0] ADDR_TAPS   = 8'hF2;
  localparam logic [7:0] ADDR_KEYEN  = 8'hF3;
  localparam logic [7:0] ADDR_TMCTL  = 8'hF4;
  localparam logic [7:0] ADDR_KEYFLG = 8'hF5;
  localparam logic [7:0] DISP_LO     = 8'hE0;
  localparam logic [7:0] DISP_HI     = 8'hEF;
  localparam logic [7:0] RAM_HI      = 8'h3F;
  localparam logic [7:0] RWIN_HI     = 8'h0F;
  localparam int         BIT_TMCLR   = 3;
  localparam int         BIT_T2EN    = 2;
  localparam int         BIT_T16EN   = 1;
  localparam int         BIT_T32EN   = 0;
  localparam int         BIT_KEYFLG  = 0;
  localparam logic [3:0] NIB_RESET   = 4'h0;
  localparam logic [7:0] PC_STEP_RST = 8'h00;
  localparam logic [3:0] PC_PAGE_RST = 4'h1;
  localparam logic [3:0] NPP_RST     = 4'h1;
  localparam int         STACK_WORDS = 3;
  localparam int         CLK_HZ      = 200000000;
  localparam int         PIN_MS      = 5;
  localparam int         KEY_S       = 4;
  localparam int         OSC_HZ      = 32768;
  localparam int         PIN_CYC     = (CLK_HZ / 1000) * PIN_MS;
  localparam longint     KEY_CYC     = longint'(CLK_HZ) * KEY_S;
  localparam int         DIV_BITS    = 15;
  localparam int         TAP16_BIT   = 10;
  localparam int         TAP32_BIT   = 9;
  localparam int         TAP2_BIT    = 13;
  localparam int         OSC_LOST    = 64;
  typedef enum logic [1:0] {
    KEYSEL_OFF = 2'b00,
    KEYSEL_01  = 2'b01,
    KEYSEL_012 = 2'b11,
    KEYSEL_ALL = 2'b10
  } keysel_type;
endpackage : rstio_pkg

/* File: hdl/sync2.sv */
`timescale 1ns/1ps
module sync2 (
  input  wire logic mclk,
  input  wire logic nrst,
  input  wire logic din,
  output logic      dout
);
  logic meta_ff;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      meta_ff <= 1'b0;
      dout    <= 1'b0;
    end else begin
      meta_ff <= din;
      dout    <= meta_ff;
    end
  end
endmodule : sync2

/* File: tb/cpu_model.sv */
`timescale 1ns/1ps
module cpu_model (
  input  wire logic       mclk,
  input  wire logic [3:0] mem_rdata,
  input  wire logic       mem_hit,
  output logic            mem_rd,
  output logic            mem_wr,
  output logic      [7:0] mem_addr,
  output logic      [3:0] mem_wdata
);
  initial begin
    mem_rd = 1'b0;
    mem_wr = 1'b0;
    mem_addr = 8'h00;
    mem_wdata = 4'h0;
  end
  // One nibble per strobe cycle; released bus shows inverted values
  task automatic access(input logic w, input logic [7:0] a, input logic [3:0] d,
                        output logic [3:0] q, output logic h);
    @(posedge mclk);
    #1;
    mem_rd = !w;
    mem_wr = w;
    mem_addr = a;
    mem_wdata = d;
    @(posedge mclk);
    #1;
    mem_rd = 1'b0;
    mem_wr = 1'b0;
    mem_addr = ~a;
    mem_wdata = ~d;
    q = mem_rdata;
    h = mem_hit;
  endtask : access
endmodule : cpu_model

/* File: tb/rstio_monitor.sv */
`timescale 1ns/1ps
module rstio_monitor #(
  parameter int PIN_CYCLES = 20
) (
  input wire logic       mclk,
  input wire logic       nrst,
  input wire logic       reset_pin,
  input wire logic       bit0_is_clock_out,
  input wire logic       mem_rd,
  input wire logic       mem_wr,
  input wire logic [7:0] mem_addr,
  input wire logic [3:0] mem_wdata,
  input wire logic [3:0] mem_rdata,
  input wire logic       mem_hit,
  input wire logic       init_reset,
  input wire logic [7:0] pc_step_init,
  input wire logic [3:0] pc_page_init,
  input wire logic [3:0] npp_init,
  input wire logic       flags_clear,
  input wire logic [3:0] out_pins,
  input wire logic       clock_out_enable,
  input wire logic       tone_inv_enable,
  input wire logic       tone_enable,
  input wire logic       tick2_irq_enable,
  input wire logic       tick16_irq_enable,
  input wire logic       tick32_irq_enable,
  input wire logic       key_irq_flag,
  input wire logic       key_irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  logic [7:0] pin_cnt_ff;
  // Consecutive cycles with the pin high, saturating
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) pin_cnt_ff <= 8'h00;
    else pin_cnt_ff <= reset_pin ? pin_cnt_ff + {7'h00, ~&pin_cnt_ff} : 8'h00;
  end
  a_pc_const: assert property (pc_step_init == 8'h00 && pc_page_init == 4'h1
    && npp_init == 4'h1) else $error("cpu reset constants wrong");
  a_flags_follow: assert property ($stable(init_reset) ##1 $stable(init_reset)
    |-> flags_clear == init_reset) else $error("flag clear does not follow reset");
  a_hit_range: assert property (mem_hit == ($past(mem_rd) && !$past(init_reset)
    && ($past(mem_addr) inside {[8'hF0:8'hF5]}))) else $error("hit wrong");
  a_rdata_idle: assert property (!$past(mem_rd) || $past(init_reset)
    |-> mem_rdata == 4'h0) else $error("read data not zero when idle");
  a_flag_upper: assert property ($past(mem_rd) && $past(mem_addr) == 8'hF5
    |-> mem_rdata[3:1] == 3'h0) else $error("flag upper bits not zero");
  a_pin_reset: assert property (pin_cnt_ff == PIN_CYCLES + 6 |-> init_reset)
    else $error("long pin pulse gave no reset");
  a_pin_release: assert property ($fell(reset_pin) && pin_cnt_ff > PIN_CYCLES + 6
    |-> ##[1:6] !init_reset) else $error("reset not released after pin");
  a_write_latch: assert property (mem_wr && !init_reset && mem_addr == 8'hF1
    |-> ##2 out_pins == $past(mem_wdata, 2)) else $error("output latch not written");
  a_tick_enables: assert property (mem_wr && !init_reset && mem_addr == 8'hF4
    |-> ##2 {tick2_irq_enable, tick16_irq_enable, tick32_irq_enable}
    == $past(mem_wdata[2:0], 2)) else $error("tick enables not written");
  a_tone_map: assert property ($stable(bit0_is_clock_out) |-> tone_enable == out_pins[1]
    && clock_out_enable == (out_pins[0] & bit0_is_clock_out)
    && tone_inv_enable == (out_pins[0] & !bit0_is_clock_out)) else $error("tone map wrong");
  a_key_copy: assert property (key_irq == key_irq_flag)
    else $error("key irq differs from flag");
endmodule : rstio_monitor
bind reset_and_io_register_map rstio_monitor #(.PIN_CYCLES(PIN_CYCLES)) rstio_monitor_inst (
  .mclk, .nrst, .reset_pin, .bit0_is_clock_out, .mem_rd, .mem_wr, .mem_addr, .mem_wdata,
  .mem_rdata, .mem_hit, .init_reset, .pc_step_init, .pc_page_init, .npp_init, .flags_clear,
  .out_pins, .clock_out_enable, .tone_inv_enable, .tone_enable, .tick2_irq_enable,
  .tick16_irq_enable, .tick32_irq_enable, .key_irq_flag, .key_irq);

/* File: tb/tb.sv */
`timescale 1ns/1ps
module tb;
  logic       mclk, nrst, osc_clk, osc_run, reset_pin, bit0_is_clock_out, mem_rd, mem_wr;
  logic       mem_hit, init_reset, flags_clear, key_irq_flag, key_irq, tone_enable;
  logic       clock_out_enable, tone_inv_enable, tick2_irq_enable, tick16_irq_enable;
  logic       tick32_irq_enable;
  logic [1:0] key_sel;
  logic [3:0] key_in, mem_wdata, mem_rdata, out_pins, pc_page_init, npp_init;
  logic [7:0] mem_addr, pc_step_init;
  int         err_total, tests_run, cyc;
  logic [7:0] wa [5] = '{8'hF1, 8'hF3, 8'hF4, 8'hF5, 8'hF0};
  logic [3:0] wm [5] = '{4'hF, 4'hF, 4'h7, 4'h0, 4'h0};
  logic [1:0] ks [5] = '{2'b00, 2'b01, 2'b11, 2'b10, 2'b10};
  logic [3:0] kp [5] = '{4'hF, 4'h3, 4'h7, 4'h7, 4'hF};
  logic [4:0] ke = 5'b10110;
  reset_and_io_register_map #(.PIN_CYCLES(20), .KEY_CYCLES(40)) reset_and_io_register_map_inst (
    .mclk, .nrst, .osc_clk, .reset_pin, .key_in, .key_sel, .bit0_is_clock_out, .mem_rd,
    .mem_wr, .mem_addr, .mem_wdata, .mem_rdata, .mem_hit, .init_reset, .pc_step_init,
    .pc_page_init, .npp_init, .flags_clear, .out_pins, .clock_out_enable, .tone_inv_enable,
    .tone_enable, .tick2_irq_enable, .tick16_irq_enable, .tick32_irq_enable, .key_irq_flag,
    .key_irq);
  cpu_model cpu_model_inst (.mclk, .mem_rdata, .mem_hit, .mem_rd, .mem_wr, .mem_addr,
    .mem_wdata);
  ////////////////////////////////////////
  always #2.5 mclk = ~mclk;
  always #25 if (osc_run) osc_clk = ~osc_clk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      stop_test();
    end
  end
  ////////////////////////////////////////
  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test
  task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : step
  task automatic wr(input logic [7:0] a, input logic [3:0] d);
    logic [3:0] q;
    logic       h;
    cpu_model_inst.access(1'b1, a, d, q, h);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [3:0] exp);
    logic [3:0] q;
    logic       h;
    cpu_model_inst.access(1'b0, a, 4'h0, q, h);
    chk("read data", exp, q);
    chk("hit", {3'h0, (a inside {[8'hF0:8'hF5]})}, {3'h0, h});
  endtask : rd
  task automatic wait_rel();
    int n = 0;
    while (init_reset !== 1'b0 && n < 300) begin
      @(posedge mclk);
      n++;
    end
    step(1);
    chk("reset release", 4'h0, {3'h0, init_reset});
  endtask : wait_rel
  ////////////////////////////////////////
  initial begin
    {mclk, nrst, osc_clk, reset_pin, key_sel, key_in, err_total, tests_run, cyc} = '0;
    osc_run = 1'b1;
    bit0_is_clock_out = 1'b1;
    step(12);
    nrst = 1'b1;
    wait_rel();
    foreach (wa[i]) rd(wa[i], 4'h0);
    foreach (wa[i]) for (int j = 0; j < 2; j++) begin
      wr(wa[i], 4'hA >> (j * 1));
      rd(wa[i], (4'hA >> (j * 1)) & wm[i]);
    end
    rd(8'hE5, 4'h0);
    rd(8'h40, 4'h0);
    rd(8'hF6, 4'h0);
    for (int s = 0; s < 2; s++) begin
      bit0_is_clock_out = s[0];
      wr(8'hF1, 4'h3);
      step(2);
      chk("pins", 4'h3, out_pins);
      chk("enables", {1'b0, s[0], !s[0], 1'b1},
          {1'b0, clock_out_enable, tone_inv_enable, tone_enable});
    end
    wr(8'hF3, 4'h1);
    key_in = 4'h5;
    step(6);
    chk("key irq", 4'h1, {3'h0, key_irq});
    rd(8'hF0, 4'h5);
    rd(8'hF5, 4'h1);
    rd(8'hF5, 4'h0);
    key_in = 4'h7;
    step(6);
    rd(8'hF5, 4'h0);
    wr(8'hF4, 4'h8);
    rd(8'hF2, 4'h0);
    rd(8'hF4, 4'h0);
    key_in = 4'h0;
    reset_pin = 1'b1;
    step(10);
    reset_pin = 1'b0;
    step(4);
    chk("short pin", 4'h0, {3'h0, init_reset});
    wr(8'hF1, 4'hF);
    reset_pin = 1'b1;
    step(30);
    chk("long pin", 4'h1, {3'h0, init_reset});
    reset_pin = 1'b0;
    wait_rel();
    rd(8'hF1, 4'h0);
    foreach (ks[i]) begin
      key_sel = ks[i];
      key_in = kp[i];
      step(60);
      chk("key reset", {3'h0, ke[i]}, {3'h0, init_reset});
      key_in = 4'h0;
      wait_rel();
    end
    osc_run = 1'b0;
    step(100);
    chk("osc stop", 4'h1, {3'h0, init_reset});
    osc_run = 1'b1;
    wait_rel();
    stop_test();
  end
endmodule : tb
